// *** rtl/sldsp_pkg.sv ***
// Package for the status LED fault display block
package sldsp_pkg;
  // Clock rate and timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SCROLL_STEP_MS = 250; // Scroll step period
  localparam int unsigned SCROLL_CYC = CLK_HZ / 1000 * SCROLL_STEP_MS;
  localparam int unsigned RAMP_STEP_US = 20; // Time per ramp level step
  localparam int unsigned RAMP_CYC = CLK_HZ / 1_000_000 * RAMP_STEP_US;
  // AXI4-Lite register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] SEG_OFS = 8'h08;
  localparam logic [7:0] PARAM_OFS = 8'h0c;
  // Control field positions
  localparam int CTRL_RC_BIT = 0; // Radio control mode
  localparam int CTRL_MIX_BIT = 1; // Mixed steering configuration
  localparam int CTRL_EDIT_BIT = 2; // Parameter editing active
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] PARAM_RST = 32'h0000_0000;
  // Software revision digits, arbitrary values
  localparam logic [3:0] REV_D0 = 4'h1;
  localparam logic [3:0] REV_D1 = 4'h0;
  // Segment bits: {g,f,e,d,c,b,a}
  localparam logic [6:0] SEG_FREE = 7'h40; // Centre bar only
  localparam logic [6:0] SEG_BLANK = 7'h00;
  // Scrolling message glyphs, four per message
  localparam logic [27:0] MSG_NOCTL = {7'h54, 7'h5c, 7'h3f, 7'h39}; // n, o, O, C
  localparam logic [27:0] MSG_ESTOP = {7'h79, 7'h6d, 7'h78, 7'h73}; // E, S, t, P
  // Display source
  typedef enum logic [2:0] {
    SLD_SRC_DIR, SLD_SRC_FREE, SLD_SRC_NOCTL, SLD_SRC_ESTOP, SLD_SRC_PARAM, SLD_SRC_TEST
  } sld_src_t;
  // Self-test phase
  typedef enum logic [2:0] {
    SLD_ST_REV0, SLD_ST_REV1, SLD_ST_M1F, SLD_ST_M1R, SLD_ST_M2F, SLD_ST_M2R
  } sld_st_t;
endpackage : sldsp_pkg

// *** rtl/sldsp_top.sv ***
// Status LED fault display with AXI4-Lite control registers
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sldsp_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Power stage commands from the motor control logic
  input wire logic dir1_rev,
  input wire logic dir2_rev,
  input wire logic out_off,
  input wire logic estop,
  // Radio detection, asynchronous pins
  input wire logic rc1_valid,
  input wire logic rc2_valid,
  // Buttons, asynchronous pins, active low
  input wire logic btn_prog_n,
  input wire logic btn_set_n,
  // Display and motor outputs
  output logic [6:0] seg,
  output logic motor_enable,
  output logic test_drive,
  output logic [7:0] test_level1,
  output logic test_level2_dummy
);
  import sldsp_pkg::*;

  // Segment pattern from two direction bits
  function automatic logic [6:0] dir_glyph(input logic r1, input logic r2);
    // Motor 1 bit lights the f/e pair, motor 2 bit the c/b pair
    // Bottom bar always lit so both-forward never looks blank
    dir_glyph = {1'b0, r1, r1, 1'b1, r2, r2, 1'b0};
  endfunction

  // Nibble to digit glyph
  function automatic logic [6:0] hex_glyph(input logic [3:0] v);
    unique case (v)
      4'h0: hex_glyph = 7'h3f;
      4'h1: hex_glyph = 7'h06;
      4'h2: hex_glyph = 7'h5b;
      4'h3: hex_glyph = 7'h4f;
      4'h4: hex_glyph = 7'h66;
      4'h5: hex_glyph = 7'h6d;
      4'h6: hex_glyph = 7'h7d;
      4'h7: hex_glyph = 7'h07;
      4'h8: hex_glyph = 7'h7f;
      4'h9: hex_glyph = 7'h6f;
      default: hex_glyph = 7'h79;
    endcase
  endfunction

  // Pin synchronisers, stage one read only by stage two
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Radio starts invalid so motors never enable on a stale level
      sync1_q <= 4'hc;
      sync2_q <= 4'hc;
    end else begin
      sync1_q <= {btn_set_n, btn_prog_n, rc2_valid, rc1_valid};
      sync2_q <= sync1_q;
    end
  end
  wire logic rc1_s = sync2_q[0];
  wire logic rc2_s = sync2_q[1];
  wire logic buttons_held = ~sync2_q[2] & ~sync2_q[3];

  // Registers
  logic [31:0] ctrl_q;
  logic [31:0] param_q;

  // Radio enable decision
  logic radio_ok;
  always_comb begin
    if (ctrl_q[CTRL_MIX_BIT]) begin
      radio_ok = rc1_s & rc2_s;
    end else begin
      radio_ok = rc1_s | rc2_s;
    end
  end

  // Self-test entry window just after reset release
  logic [2:0] boot_q; // Cycles since reset, saturating
  logic test_q; // Self-test latched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_q <= 3'h0;
      test_q <= 1'b0;
    end else begin
      if (boot_q != 3'h7) begin
        boot_q <= boot_q + 3'h1;
      end
      // Sample buttons once the synchroniser has settled
      if (boot_q == 3'h3 && buttons_held) begin
        test_q <= 1'b1;
      end
    end
  end

  // Scroll step timer shared by messages and self-test
  logic [31:0] tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == SCROLL_CYC - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end

  // Message scroll index, restarts whenever the source changes
  sld_src_t src;
  sld_src_t src_q;
  logic [1:0] scroll_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scroll_q <= 2'h0;
      src_q <= SLD_SRC_DIR;
    end else begin
      src_q <= src;
      if (src != src_q) begin
        scroll_q <= 2'h0;
      end else if (tick) begin
        scroll_q <= scroll_q + 2'h1;
      end
    end
  end

  // Self-test sequencer; ramps at a fine step, phases loop forever
  sld_st_t st_q;
  logic [7:0] ramp_q;
  logic [31:0] ramp_cnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= SLD_ST_REV0;
      ramp_q <= 8'h00;
      ramp_cnt_q <= '0;
    end else if (test_q) begin
      unique case (st_q)
        SLD_ST_REV0: if (tick) st_q <= SLD_ST_REV1;
        SLD_ST_REV1: if (tick) st_q <= SLD_ST_M1F;
        default: begin
          if (ramp_cnt_q == RAMP_CYC - 1) begin
            ramp_cnt_q <= '0;
            if (ramp_q == 8'hff) begin
              ramp_q <= 8'h00;
              unique case (st_q)
                SLD_ST_M1F: st_q <= SLD_ST_M1R;
                SLD_ST_M1R: st_q <= SLD_ST_M2F;
                SLD_ST_M2F: st_q <= SLD_ST_M2R;
                default: st_q <= SLD_ST_REV0;
              endcase
            end else begin
              ramp_q <= ramp_q + 8'h01;
            end
          end else begin
            ramp_cnt_q <= ramp_cnt_q + 32'h1;
          end
        end
      endcase
    end
  end
  wire logic st_rev = (st_q == SLD_ST_REV0) || (st_q == SLD_ST_REV1);
  wire logic st_m1r = (st_q == SLD_ST_M1R);
  wire logic st_m2r = (st_q == SLD_ST_M2R);

  // Source selection; faults and self-test win over direction
  always_comb begin
    if (test_q) begin
      src = SLD_SRC_TEST;
    end else if (estop) begin
      src = SLD_SRC_ESTOP;
    end else if (ctrl_q[CTRL_RC_BIT] && !radio_ok) begin
      src = SLD_SRC_NOCTL;
    end else if (ctrl_q[CTRL_EDIT_BIT]) begin
      src = SLD_SRC_PARAM;
    end else if (out_off) begin
      src = SLD_SRC_FREE;
    end else begin
      src = SLD_SRC_DIR;
    end
  end

  // Segment drive; direction ignores power, zero command is forward
  logic [6:0] seg_d;
  always_comb begin
    unique case (src_q)
      SLD_SRC_TEST: begin
        if (st_rev) begin
          // Flash: blank on odd scroll steps
          seg_d = scroll_q[0] ? SEG_BLANK
                : hex_glyph(st_q == SLD_ST_REV0 ? REV_D0 : REV_D1);
        end else begin
          seg_d = dir_glyph(st_m1r, st_m2r);
        end
      end
      SLD_SRC_ESTOP: seg_d = MSG_ESTOP[27 - 7 * scroll_q -: 7];
      SLD_SRC_NOCTL: seg_d = MSG_NOCTL[27 - 7 * scroll_q -: 7];
      SLD_SRC_PARAM: seg_d = scroll_q[0] ? hex_glyph(param_q[3:0]) : hex_glyph(param_q[11:8]);
      SLD_SRC_FREE: seg_d = SEG_FREE;
      default: seg_d = dir_glyph(dir1_rev, dir2_rev);
    endcase
  end

  // Registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seg <= SEG_BLANK;
      motor_enable <= 1'b0;
      test_drive <= 1'b0;
      test_level1 <= 8'h00;
      test_level2_dummy <= 1'b0;
    end else begin
      seg <= seg_d;
      // Motors held off while any fault message is up
      motor_enable <= (src == SLD_SRC_DIR) || (src == SLD_SRC_FREE)
                    || (src == SLD_SRC_PARAM);
      test_drive <= test_q && !st_rev;
      test_level1 <= ramp_q;
      test_level2_dummy <= st_m2r || (st_q == SLD_ST_M2F);
    end
  end

  // AXI4-Lite write channel: accept both, answer once
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire logic do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == CTRL_OFS || awaddr_q == PARAM_OFS) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;

  // Register storage with byte strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      param_q <= PARAM_RST;
    end else if (do_write) begin
      for (int i = 0; i < 4; i++) begin
        if (wstrb_q[i] && awaddr_q == CTRL_OFS) ctrl_q[8*i +: 8] <= wdata_q[8*i +: 8];
        if (wstrb_q[i] && awaddr_q == PARAM_OFS) param_q[8*i +: 8] <= wdata_q[8*i +: 8];
      end
    end
  end

  // AXI4-Lite read channel, one cycle answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      unique case (s_axi_araddr)
        CTRL_OFS: s_axi_rdata <= ctrl_q;
        STAT_OFS: s_axi_rdata <= {23'h0, st_q, src_q, radio_ok, test_q, motor_enable};
        SEG_OFS: s_axi_rdata <= {25'h0, seg};
        PARAM_OFS: s_axi_rdata <= param_q;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // Checks
  no_ctl_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!test_q && !estop && ctrl_q[CTRL_RC_BIT] && !radio_ok) |=> src_q == SLD_SRC_NOCTL)
    else $error("no-control not selected");
  mix_need_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_q[CTRL_MIX_BIT] && !(rc1_s && rc2_s)) |-> !radio_ok)
    else $error("mixed mode enabled on one channel");
  sep_any_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ctrl_q[CTRL_MIX_BIT] && (rc1_s || rc2_s)) |-> radio_ok)
    else $error("separate mode not enabled");
  free_pat_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (src_q == SLD_SRC_FREE) |=> seg == SEG_FREE)
    else $error("freewheel pattern wrong");
  dir_pat_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (src_q == SLD_SRC_DIR && !dir1_rev && !dir2_rev) |=> seg == dir_glyph(1'b0, 1'b0))
    else $error("forward pattern wrong");
  fault_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (src == SLD_SRC_ESTOP || src == SLD_SRC_NOCTL) |=> !motor_enable)
    else $error("motors enabled during fault");
  test_prio_a: assert property (@(posedge aclk) disable iff (!aresetn)
    test_q |=> src_q == SLD_SRC_TEST)
    else $error("self-test not prioritised");
  test_stay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    test_q |=> test_q)
    else $error("self-test left without reset");
endmodule : sldsp_top
`default_nettype wire

// *** verification/sldsp_far_model.sv ***
// Far-side model: the seven-segment lamps seen by an observer
`timescale 1ns/1ps
`default_nettype none
module sldsp_far_model (
  // Clock
  input wire logic aclk,
  // Segment drive from the block
  input wire logic [6:0] seg,
  // Lamps currently lit
  output logic [2:0] lit_cnt
);
  // Count lit lamps; a stuck segment shows up as a wrong count
  always_ff @(posedge aclk) begin
    lit_cnt <= 3'($countones(seg));
  end
endmodule // sldsp_far_model
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the status display block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sldsp_pkg::*;
  // Clock, reset and bus
  logic aclk = 0, aresetn = 0;
  logic awv = 0, awr, wv = 0, wr, bv, br = 0, arv = 0, arr, rv, rr = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd, r;
  logic [1:0] bresp, rresp, e;
  // Device side pins
  logic d1 = 0, d2 = 0, off = 0, es = 0, rc1 = 0, rc2 = 0, bp = 1, bs = 1;
  logic [6:0] seg, p00, m1, m2, x;
  logic men, tdrv, tl2;
  logic [7:0] tl1, lf = 8'h5e; // Seed 94
  logic [2:0] lit;
  int mismatches = 0, checked = 0;
  // 125 MHz clock
  always #4 aclk = ~aclk;
  sldsp_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .dir1_rev(d1),
    .dir2_rev(d2), .out_off(off), .estop(es), .rc1_valid(rc1), .rc2_valid(rc2),
    .btn_prog_n(bp), .btn_set_n(bs), .seg(seg), .motor_enable(men), .test_drive(tdrv),
    .test_level1(tl1), .test_level2_dummy(tl2));
  sldsp_far_model far (.aclk(aclk), .seg(seg), .lit_cnt(lit));
  // Next random value
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Expected direction pattern from the learned pairs
  function automatic logic [6:0] dir_pat(input logic a, input logic b);
    return p00 ^ (a ? m1 : 7'h00) ^ (b ? m2 : 7'h00);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Segment must show one glyph of the message
  task automatic cmp_in(input logic [27:0] msg);
    logic hit;
    hit = 0;
    for (int i = 0; i < 4; i++) if (seg === msg[27 - 7 * i -: 7]) hit = 1;
    checked++;
    if (!hit) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, seg, msg);
    end
  endtask
  // Write: address and data together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    awv <= 1;
    awa <= a;
    wv <= 1;
    wd <= d;
    br <= 1;
    // Each channel released at the edge that takes it
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awv && awr) begin
        awv <= 0;
        ta = 1;
      end
      if (wv && wr) begin
        wv <= 0;
        tw = 1;
      end
    end
    // Response taken at the edge that sees bvalid
    do @(posedge aclk); while (bv !== 1'b1);
    resp = bresp;
    br <= 0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    arv <= 1;
    ara <= a;
    rr <= 1;
    // Address released at the edge that takes it
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 0;
    // Data taken at the edge that sees rvalid
    do @(posedge aclk); while (rv !== 1'b1);
    d = rd;
    resp = rresp;
    rr <= 0;
  endtask
  // Bounded wait for the enable level, then compare it
  task automatic wait_en(input logic v);
    for (int i = 0; i < 40 && men !== v; i++) @(negedge aclk);
    cmp(men, v);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard, far beyond the expected run of a few hundred cycles
  initial begin
    cyc(20000);
    mismatches++;
    tally_and_finish;
  end
  initial begin
    cyc(1);
    @(negedge aclk);
    cmp(seg, SEG_BLANK);
    cmp(men, 1'b0);
    @(posedge aclk) aresetn <= 1;
    axi_rd(CTRL_OFS, r, e);
    cmp(r, CTRL_RST);
    axi_wr(PARAM_OFS, 32'h0000_0905, e);
    axi_rd(PARAM_OFS, r, e);
    cmp(r, 32'h0000_0905);
    axi_wr(8'h10, 32'h0000_00ff, e);
    cmp(e, 2'b10); // Unmapped write refused
    axi_rd(8'h10, r, e);
    cmp(e, 2'b10);
    $display("test regs done");
    // Radio absent: no-control glyphs, motors held
    cyc(6);
    cmp(men, 1'b0);
    cmp_in(MSG_NOCTL);
    // Separate channels: either one enables
    @(posedge aclk) rc1 <= 1;
    wait_en(1'b1);
    @(posedge aclk) begin rc1 <= 0; rc2 <= 1; end
    cyc(8);
    cmp(men, 1'b1);
    // Mixed: one channel is not enough
    axi_wr(CTRL_OFS, 32'h0000_0003, e);
    @(posedge aclk) begin rc1 <= 1; rc2 <= 0; end
    wait_en(1'b0);
    cyc(10);
    cmp(men, 1'b0);
    @(posedge aclk) rc2 <= 1;
    wait_en(1'b1);
    $display("test radio done");
    // Learn each command bit's segment pair
    cyc(6);
    p00 = seg;
    @(posedge aclk) d1 <= 1;
    cyc(6);
    m1 = seg ^ p00;
    @(posedge aclk) begin d1 <= 0; d2 <= 1; end
    cyc(6);
    m2 = seg ^ p00;
    cmp($countones(m1), 2);
    cmp($countones(m2), 2);
    cmp(m1 & m2, 7'h00);
    cmp(p00 != SEG_FREE && (p00 ^ m1 ^ m2) != SEG_FREE, 1'b1);
    for (int i = 0; i < 16; i++) begin
      lf = lfsr(lf);
      @(posedge aclk) begin d1 <= lf[0]; d2 <= lf[1]; end
      cyc(6);
      x = dir_pat(lf[0], lf[1]);
      cmp(seg, x);
      cmp(lit, $countones(x));
    end
    @(posedge aclk) begin d1 <= 0; d2 <= 0; end
    cyc(6);
    cmp(seg, p00);
    $display("test direction done");
    // Transistors off shows the centre-bar pattern
    @(posedge aclk) off <= 1;
    cyc(6);
    cmp(seg, SEG_FREE);
    @(posedge aclk) off <= 0;
    // Parameter edit shows the high digit first: 9 lights a,b,c,d,f,g
    axi_wr(CTRL_OFS, 32'h0000_0007, e);
    cyc(4);
    cmp(seg, 7'h6f);
    axi_wr(CTRL_OFS, 32'h0000_0003, e);
    // Emergency stop wins over direction and no-control
    @(posedge aclk) es <= 1;
    wait_en(1'b0);
    cyc(4);
    cmp_in(MSG_ESTOP);
    @(posedge aclk) rc1 <= 0;
    cyc(8);
    cmp_in(MSG_ESTOP);
    @(posedge aclk) es <= 0;
    $display("test faults done");
    // Buttons held across reset release start the self-test
    @(posedge aclk) begin aresetn <= 0; bp <= 0; bs <= 0; end
    cyc(2);
    @(posedge aclk) aresetn <= 1;
    cyc(12);
    @(posedge aclk) begin bp <= 1; bs <= 1; end
    axi_rd(STAT_OFS, r, e);
    cmp(r[1], 1'b1);
    cmp(men, 1'b0);
    cmp(tdrv, 1'b0);
    cmp(tl1, 8'h00);
    cmp(tl2, 1'b0);
    $display("test selftest done");
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
